/* rtl/bbo_pkg.sv */
package bbo_pkg;
  localparam int unsigned PC_W = 21;
  localparam int unsigned DA_W = 12;
  localparam int unsigned INSN_W = 16;
  localparam int unsigned PHASES = 4;
  localparam logic [1:0] PH_DECODE = 2'h0;
  localparam logic [1:0] PH_READ = 2'h1;
  localparam logic [1:0] PH_PROCESS = 2'h2;
  localparam logic [1:0] PH_WRITE = 2'h3;
  // opcode patterns
  localparam logic [7:0] OP_BRANCH_NOT_ZERO = 8'he1;
  localparam logic [3:0] OP_BRANCH_ALWAYS = 4'hd;
  localparam logic [3:0] OP_SET_BIT = 4'h8;
  localparam logic [3:0] OP_SKIP_IF_CLEAR = 4'hb;
  localparam logic [3:0] OP_SKIP_IF_SET = 4'ha;
  // data addressing
  localparam logic [7:0] ACCESS_SPLIT = 8'h80;
  localparam logic [7:0] INDEXED_MAX = 8'h5f;
  localparam logic [3:0] ACCESS_HIGH_BANK = 4'hf;
  // register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_BANK = 12'h004;
  localparam logic [11:0] OFS_INSN = 12'h008;
  localparam logic [11:0] OFS_PC = 12'h00c;
  localparam logic [11:0] OFS_STATUS = 12'h010;
  localparam logic [11:0] OFS_INDEX = 12'h014;
  localparam logic [11:0] OFS_LASTADDR = 12'h018;
  localparam logic [11:0] OFS_DATA_BASE = 12'h400;
  // control bits
  localparam int unsigned CTRL_EXT_BIT = 0;
  localparam int unsigned CTRL_ZERO_BIT = 1;
  // reset values
  localparam logic [PC_W-1:0] RST_PC = 21'h0;
  localparam logic [3:0] RST_BANK = 4'h0;
  localparam logic [DA_W-1:0] RST_INDEX = 12'h000;
  localparam logic [1:0] RST_CTRL = 2'h0;
  typedef enum logic [2:0] {
    BBO_K_NOP, BBO_K_BNZ, BBO_K_BRA, BBO_K_SETBIT, BBO_K_SKIPCLR, BBO_K_SKIPSET
  } bbo_kind_t;
  typedef enum {BBO_S_IDLE, BBO_S_EXEC, BBO_S_DEAD} bbo_state_t;
endpackage : bbo_pkg

/* rtl/bbo_exec_if.sv */
`timescale 1ns/100ps
`default_nettype none
interface bbo_exec_if;
  import bbo_pkg::*;
  logic [INSN_W-1:0] insn;
  logic [PC_W-1:0] pc_inc;
  logic [3:0] bank;
  logic [DA_W-1:0] index;
  logic ext_en;
  logic zero;
  logic [7:0] rbyte;
  bbo_kind_t kind;
  logic [DA_W-1:0] eff_addr;
  logic [PC_W-1:0] target;
  logic [7:0] wbyte;
  logic redirect;
  modport core (output insn, pc_inc, bank, index, ext_en, zero, rbyte,
    input kind, eff_addr, target, wbyte, redirect);
  modport dec (input insn, pc_inc, bank, index, ext_en, zero, rbyte,
    output kind, eff_addr, target, wbyte, redirect);
endinterface : bbo_exec_if
`default_nettype wire

/* rtl/bbo_decode.sv */
`timescale 1ns/100ps
`default_nettype none
module bbo_decode
  import bbo_pkg::*;
(
  bbo_exec_if.dec x
);
  logic [7:0] f;
  logic [2:0] bidx;
  logic acc;
  logic [PC_W-1:0] disp;
  logic bit_now;

  assign f = x.insn[7:0];
  assign bidx = x.insn[11:9];
  assign acc = x.insn[8];
  assign bit_now = x.rbyte[bidx];

  always_comb begin
    if (x.insn[15:8] == OP_BRANCH_NOT_ZERO) x.kind = BBO_K_BNZ;
    else if (x.insn[15:12] == OP_BRANCH_ALWAYS && !x.insn[11]) x.kind = BBO_K_BRA;
    else if (x.insn[15:12] == OP_SET_BIT) x.kind = BBO_K_SETBIT;
    else if (x.insn[15:12] == OP_SKIP_IF_CLEAR) x.kind = BBO_K_SKIPCLR;
    else if (x.insn[15:12] == OP_SKIP_IF_SET) x.kind = BBO_K_SKIPSET;
    else x.kind = BBO_K_NOP;
  end

  // offset doubled and sign-extended; 11-bit field spans -1024..1023
  always_comb begin
    if (x.kind == BBO_K_BRA) disp = {{(PC_W-12){x.insn[10]}}, x.insn[10:0], 1'b0};
    else disp = {{(PC_W-9){x.insn[7]}}, x.insn[7:0], 1'b0};
  end
  assign x.target = x.pc_inc + disp;

  always_comb begin
    if (acc) x.eff_addr = {x.bank, f};
    else if (x.ext_en && f <= INDEXED_MAX) x.eff_addr = x.index + {4'h0, f};
    else if (f < ACCESS_SPLIT) x.eff_addr = {4'h0, f};
    else x.eff_addr = {ACCESS_HIGH_BANK, f};
  end

  assign x.wbyte = x.rbyte | (8'h01 << bidx);

  always_comb begin
    case (x.kind)
      BBO_K_BNZ: x.redirect = !x.zero;
      BBO_K_BRA: x.redirect = 1'b1;
      BBO_K_SKIPCLR: x.redirect = !bit_now;
      BBO_K_SKIPSET: x.redirect = bit_now;
      default: x.redirect = 1'b0;
    endcase
  end
endmodule : bbo_decode
`default_nettype wire

/* rtl/bbo_top.sv */
// What this block does
// - opcode e1 plus 8-bit offset branches only when zero flag is clear
// - taken branch target is instruction address plus two plus twice offset
// - branch-not-zero takes one cycle untaken, two cycles taken
// - taken: decode, read offset, process, write pc, then a dead cycle
// - unconditional branch opcode 1101 with 11-bit signed offset
// - unconditional branch always takes two cycles, pc written in phase four
// - set-bit sets the chosen bit of the addressed register, others kept
// - access flag 0 uses access bank, 1 uses bank select register
// - extended set, access flag 0, operand up to 5f uses indexed addressing
// - skip condition met discards the fetched instruction, costs two cycles
//
// The placing of the registers and register access over AHB-Lite are this design's own decisions.
`timescale 1ns/100ps
`default_nettype none
module bbo_top
  import bbo_pkg::*;
#(
  parameter int unsigned DATA_DEPTH = 256
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic busy
);
  localparam int unsigned MI_W = $clog2(DATA_DEPTH);

  bbo_exec_if x ();
  bbo_decode u_dec (.x(x));

  bbo_state_t state;
  logic [1:0] phase;
  logic [INSN_W-1:0] cur;
  logic [INSN_W-1:0] pf;
  logic pf_valid;
  logic [PC_W-1:0] pc;
  logic [3:0] bank;
  logic [DA_W-1:0] index;
  logic [1:0] ctrl;
  logic [7:0] rbyte;
  logic take;
  logic last_redirect;
  logic [7:0] discards;
  logic [DA_W-1:0] last_addr;
  logic [7:0] mem [DATA_DEPTH];

  // bus data-phase bookkeeping
  logic dp_write;
  logic [11:0] dp_addr;
  logic [11:0] ap_addr;
  logic ap_take;
  logic wr_done;
  logic insn_load;
  logic at_end;

  function automatic logic in_data(input logic [11:0] a);
    return a >= OFS_DATA_BASE && a < OFS_DATA_BASE + 12'(4 * DATA_DEPTH);
  endfunction : in_data

  function automatic logic [MI_W-1:0] data_idx(input logic [11:0] a);
    logic [11:0] d;
    d = a - OFS_DATA_BASE;
    return d[MI_W+1:2];
  endfunction : data_idx

  assign ap_addr = haddr[11:0];
  assign ap_take = ce && hsel && htrans[1] && hready && haddr[31:12] == 20'h00000;
  assign wr_done = ce && dp_write && hreadyout;
  // the instruction slot accepts a word only once the old one has moved on
  assign insn_load = ce && dp_write && !hreadyout && dp_addr == OFS_INSN && !pf_valid;
  assign at_end = ce && state == BBO_S_EXEC && phase == PH_WRITE;

  assign x.insn = cur;
  assign x.pc_inc = pc;
  assign x.bank = bank;
  assign x.index = index;
  assign x.ext_en = ctrl[CTRL_EXT_BIT];
  assign x.zero = ctrl[CTRL_ZERO_BIT];
  assign x.rbyte = rbyte;

  // bus: address phase, wait state only for instruction writes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dp_write <= 1'b0;
      dp_addr <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else if (ce) begin
      if (ap_take) begin
        dp_write <= hwrite;
        dp_addr <= ap_addr;
        hreadyout <= !(hwrite && ap_addr == OFS_INSN);
      end else if (insn_load) begin
        dp_write <= 1'b0;
        hreadyout <= 1'b1;
      end else if (hreadyout) begin
        dp_write <= 1'b0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      hrdata <= 32'h00000000;
    end else if (ap_take && !hwrite) begin
      if (in_data(ap_addr)) hrdata <= {24'h000000, mem[data_idx(ap_addr)]};
      else begin
        case (ap_addr)
          OFS_CTRL: hrdata <= {30'h0, ctrl};
          OFS_BANK: hrdata <= {28'h0000000, bank};
          OFS_INSN: hrdata <= {16'h0000, pf};
          OFS_PC: hrdata <= {11'h0, pc};
          OFS_STATUS: hrdata <= {16'h0000, discards, 3'h0, last_redirect,
                                 phase, pf_valid, busy};
          OFS_INDEX: hrdata <= {20'h00000, index};
          OFS_LASTADDR: hrdata <= {20'h00000, last_addr};
          default: hrdata <= 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ctrl <= RST_CTRL;
      bank <= RST_BANK;
      index <= RST_INDEX;
    end else if (wr_done) begin
      case (dp_addr)
        OFS_CTRL: ctrl <= hwdata[1:0];
        OFS_BANK: bank <= hwdata[3:0];
        OFS_INDEX: index <= hwdata[DA_W-1:0];
        default: ;
      endcase
    end
  end

  // prefetch slot: a fetch landing in the flush cycle is the new path's, so load wins
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pf <= 16'h0000;
      pf_valid <= 1'b0;
    end else if (ce) begin
      if (insn_load) begin
        pf <= hwdata[INSN_W-1:0];
        pf_valid <= 1'b1;
      end else if (at_end && take) begin
        pf_valid <= 1'b0;
      end else if (pf_valid && (state == BBO_S_IDLE || at_end)) begin
        pf_valid <= 1'b0;
      end
    end
  end

  // sequencer: four phases per instruction cycle
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      state <= BBO_S_IDLE;
      phase <= PH_DECODE;
      cur <= 16'h0000;
      busy <= 1'b0;
    end else if (ce) begin
      case (state)
        BBO_S_IDLE: begin
          phase <= PH_DECODE;
          if (pf_valid) begin
            state <= BBO_S_EXEC;
            cur <= pf;
            busy <= 1'b1;
          end
        end
        BBO_S_EXEC: begin
          phase <= phase + 2'h1;
          if (phase == PH_WRITE) begin
            if (take) state <= BBO_S_DEAD;
            else if (pf_valid) cur <= pf;
            else begin
              state <= BBO_S_IDLE;
              busy <= 1'b0;
            end
          end
        end
        BBO_S_DEAD: begin
          phase <= phase + 2'h1;
          if (phase == PH_WRITE) begin
            state <= BBO_S_IDLE;
            busy <= 1'b0;
          end
        end
        default: begin
          state <= BBO_S_IDLE;
          busy <= 1'b0;
        end
      endcase
    end
  end

  // read phase latches the operand, process phase decides the redirect
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rbyte <= 8'h00;
      take <= 1'b0;
      last_addr <= 12'h000;
    end else if (ce && state == BBO_S_EXEC) begin
      if (phase == PH_DECODE) take <= 1'b0;
      if (phase == PH_READ) begin
        last_addr <= x.eff_addr;
        if (x.eff_addr < 12'(DATA_DEPTH)) rbyte <= mem[x.eff_addr[MI_W-1:0]];
        else rbyte <= 8'h00;
      end
      if (phase == PH_PROCESS) take <= x.redirect;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pc <= RST_PC;
    end else if (ce) begin
      if (state == BBO_S_EXEC && phase == PH_DECODE) pc <= pc + 21'h2;
      else if (at_end && take && (x.kind == BBO_K_BNZ || x.kind == BBO_K_BRA))
        pc <= x.target;
      else if (at_end && take)
        pc <= pc + 21'h2;
      else if (wr_done && dp_addr == OFS_PC && state == BBO_S_IDLE)
        pc <= hwdata[PC_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_redirect <= 1'b0;
      discards <= 8'h00;
    end else if (at_end) begin
      last_redirect <= take;
      if (take && pf_valid) discards <= discards + 8'h01;
    end
  end

  // both writes may land; on the same byte the later one, the operand write, wins
  always_ff @(posedge clk) begin
    if (wr_done && in_data(dp_addr)) mem[data_idx(dp_addr)] <= hwdata[7:0];
    if (at_end && x.kind == BBO_K_SETBIT && last_addr < 12'(DATA_DEPTH))
      mem[last_addr[MI_W-1:0]] <= x.wbyte;
  end
endmodule : bbo_top
`default_nettype wire

/* test/bbo_checker.sv */
`timescale 1ns/100ps
`default_nettype none
module bbo_checker
  import bbo_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic busy
);
  logic wph, zf, tk, acc;
  logic [11:0] wad;
  logic [7:0] run;
  assign tk = ce && hsel && htrans[1] && hready;
  assign acc = ce && hready && wph && wad == OFS_INSN;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wph <= 1'b0;
      wad <= 12'h0;
    end else if (ce && hready) begin
      wph <= tk && hwrite && haddr[31:12] == 20'h0;
      wad <= haddr[11:0];
    end
  end
  // mirror of the zero flag so branch length can be predicted
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) zf <= 1'b0;
    else if (ce && hready && wph && wad == OFS_CTRL) zf <= hwdata[CTRL_ZERO_BIT];
  end
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) run <= 8'h0;
    else run <= busy ? run + 8'h1 : 8'h0;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);
  chk_busy_whole: assert property ($fell(busy) |-> run[1:0] == 2'h0 && run != 8'h0)
    else $error("busy run not whole instruction cycles");
  chk_bra_two: assert property (acc && !busy && hwdata[15:12] == OP_BRANCH_ALWAYS
    |-> ##[1:4] $rose(busy) ##0 busy[*8]) else $error("relative branch not two cycles");
  chk_bnz_taken: assert property (acc && !busy && hwdata[15:8] == OP_BRANCH_NOT_ZERO && !zf
    |-> ##[1:4] $rose(busy) ##0 busy[*8]) else $error("taken branch not two cycles");
  chk_bnz_plain: assert property (acc && !busy && hwdata[15:8] == OP_BRANCH_NOT_ZERO && zf
    |-> ##[1:4] $rose(busy) ##0 busy[*4] ##1 !busy) else $error("untaken branch not one cycle");
  chk_setbit_one: assert property (acc && !busy && hwdata[15:12] == OP_SET_BIT
    |-> ##[1:4] $rose(busy) ##0 busy[*4] ##1 !busy) else $error("set bit not one cycle");
  chk_skip_len: assert property (acc && !busy && hwdata[15:13] == 3'h5
    |-> ##[5:13] $fell(busy) && (run == 8'h4 || run == 8'h8)) else $error("skip length wrong");
  chk_insn_wait: assert property (tk && hwrite && haddr == {20'h0, OFS_INSN} |=> !hreadyout)
    else $error("instruction write without wait state");
  chk_read_fast: assert property (tk && !hwrite |=> hreadyout)
    else $error("read not zero wait");
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("response not okay");
endmodule : bbo_checker
bind bbo_top bbo_checker chk_u (.clk(clk), .nrst(nrst), .ce(ce), .hsel(hsel), .haddr(haddr),
  .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout),
  .hresp(hresp), .busy(busy));
`default_nettype wire

/* test/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import bbo_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, hresp, busy;
  logic [15:0] lf = 16'h0045;
  logic [11:0] rz [6] = '{OFS_CTRL, OFS_BANK, OFS_PC, OFS_STATUS, OFS_INDEX, OFS_LASTADDR};
  int miscompares = 0;
  int compares = 0;
  int cyc = 0;
  always #2.5 clk = ~clk;
  bbo_top dut_u (.clk(clk), .nrst(nrst), .ce(1'b1), .hsel(1'b1), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .busy(busy));
  function automatic logic [15:0] nx(logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction : nx
  function automatic logic [20:0] tgt(logic [20:0] p, logic [10:0] n);
    return p + 21'h2 + {{9{n[10]}}, n, 1'b0};
  endfunction : tgt
  function automatic logic [11:0] eaddr(logic a, logic x, logic [7:0] f, logic [3:0] k,
    logic [11:0] ix);
    if (a) return {k, f};
    if (x && f <= INDEXED_MAX) return ix + {4'h0, f};
    if (f < ACCESS_SPLIT) return {4'h0, f};
    return {ACCESS_HIGH_BANK, f};
  endfunction : eaddr
  task automatic test_done;
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : test_done
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      miscompares++;
      $display("[ERR] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    xfer(1'b1, {20'h0, a}, d);
  endtask : wr
  task automatic get(input logic [11:0] a);
    xfer(1'b0, {20'h0, a}, 32'h0);
  endtask : get
  task automatic rc(input logic [11:0] a, input logic [31:0] e);
    get(a);
    chk(rd, e);
  endtask : rc
  // status poll, not a fixed wait: execution length is what is under test
  task automatic go(input logic [15:0] ins);
    wr(OFS_INSN, {16'h0, ins});
    repeat (2) @(posedge clk);
    do get(OFS_STATUS); while (rd[1:0] !== 2'h0);
  endtask : go
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      miscompares++;
      test_done();
    end
  end
  initial begin
    logic [20:0] p;
    logic [10:0] n;
    logic [7:0] f, v, c;
    logic [2:0] b;
    logic [3:0] k;
    logic [11:0] e;
    logic a, x, m;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    xfer(1'b1, 32'h0001_0000, 32'hffff_ffff);
    xfer(1'b0, 32'h0001_0000, 32'h0);
    chk(rd, 32'h0);
    foreach (rz[i]) rc(rz[i], 32'h0);
    for (int i = 0; i < 6; i++) begin
      lf = nx(lf);
      n = i < 2 ? 11'h780 : i < 4 ? 11'h07f : {{3{lf[7]}}, lf[7:0]};
      p = {5'h0, lf[15:1], 1'b0};
      wr(OFS_PC, {11'h0, p});
      wr(OFS_CTRL, {30'h0, i[0], 1'b0});
      go({OP_BRANCH_NOT_ZERO, n[7:0]});
      rc(OFS_PC, {11'h0, i[0] ? p + 21'h2 : tgt(p, n)});
      get(OFS_STATUS);
      chk({31'h0, rd[4]}, {31'h0, !i[0]});
    end
    for (int i = 0; i < 3; i++) begin
      lf = nx(lf);
      n = i == 0 ? 11'h400 : i == 1 ? 11'h3ff : lf[10:0];
      p = {5'h0, lf[14:0], 1'b0};
      f = {1'b0, lf[7:1]};
      wr(OFS_PC, {11'h0, p});
      wr(OFS_DATA_BASE + {2'h0, f, 2'h0}, 32'h0);
      get(OFS_STATUS);
      c = rd[15:8];
      wr(OFS_INSN, {OP_BRANCH_ALWAYS, 1'b0, n});
      // queued behind the branch, so it must be thrown away
      go({OP_SET_BIT, 3'h0, 1'b0, f});
      rc(OFS_PC, {11'h0, tgt(p, n)});
      rc(OFS_DATA_BASE + {2'h0, f, 2'h0}, 32'h0);
      get(OFS_STATUS);
      chk({24'h0, rd[15:8]}, {24'h0, c + 8'h1});
    end
    for (int i = 0; i < 8; i++) begin
      lf = nx(lf);
      a = i > 1 && lf[0];
      x = i < 2 || lf[1];
      f = i == 0 ? INDEXED_MAX : i == 1 ? INDEXED_MAX + 8'h1 : lf[15:8];
      b = lf[4:2];
      k = {3'h0, lf[5]};
      e = eaddr(a, x, f, k, {7'h0, lf[10:6]});
      wr(OFS_CTRL, {31'h0, x});
      wr(OFS_BANK, {28'h0, k});
      wr(OFS_INDEX, {27'h0, lf[10:6]});
      v = lf[12:5] ^ 8'ha5;
      if (e < 12'h100) wr(OFS_DATA_BASE + {2'h0, e[7:0], 2'h0}, {24'h0, v});
      go({OP_SET_BIT, b, a, f});
      rc(OFS_LASTADDR, {20'h0, e});
      if (e < 12'h100) rc(OFS_DATA_BASE + {2'h0, e[7:0], 2'h0}, {24'h0, v | (8'h1 << b)});
    end
    wr(OFS_BANK, 32'h0);
    for (int i = 0; i < 4; i++) begin
      lf = nx(lf);
      f = i == 3 ? 8'hff : lf[7:0];
      b = lf[10:8];
      v = lf[15:8];
      v[b] = i[0];
      m = i[1] == i[0];
      p = {5'h0, lf[15:1], 1'b0};
      wr(OFS_PC, {11'h0, p});
      wr(OFS_DATA_BASE + {2'h0, f, 2'h0}, {24'h0, v});
      go({i[1] ? OP_SKIP_IF_SET : OP_SKIP_IF_CLEAR, b, 1'b1, f});
      rc(OFS_PC, {11'h0, p + (m ? 21'h4 : 21'h2)});
      get(OFS_STATUS);
      chk({31'h0, rd[4]}, {31'h0, m});
    end
    test_done();
  end
endmodule : tb_top
`default_nettype wire
